// ==== bench/vcmbd_decoder_tb.sv ====
`timescale 1ns/1ps
module vcmbd_decoder_tb;
  import vcmbd_pkg::*;
  logic          pclk;
  logic          presetn;
  logic          clk_en;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [11:0]   paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  vcmbd_params_t mb_params;
  logic [5:0]    fetch_mask;
  logic          mb_valid;
  logic          mb_error;
  logic          hung;
  vcmbd_params_t last_p;
  logic [5:0]    last_f;
  logic [31:0]   rd;
  logic          er;
  int            err_count;
  int            num_checks;
  // only the commands the decoder must accept
  logic [51:0]   good_tab [5] = '{
    {4'hd, 32'h0562_0a90, 16'hff00},
    {4'h9, 32'h0433_0fd0, 16'h00ff},
    {4'ha, 32'h020a_afe0, 16'h1234},
    {4'hc, 32'h0206_0040, 16'hffff},
    {4'ha, 32'h0200_0000, 16'h0000}};
  logic [35:0]   bad_tab [13] = '{
    {4'hd, 32'h0302_0000}, {4'hd, 32'h0002_0000}, {4'ha, 32'h0122_0000},
    {4'hd, 32'h0102_0000}, {4'hd, 32'h0222_0000}, {4'ha, 32'h0021_0fc0},
    {4'h9, 32'h020a_0000}, {4'ha, 32'h0208_0000}, {4'ha, 32'h020e_0000},
    {4'ha, 32'h0202_f000}, {4'hd, 32'h0001_0f80}, {4'ha, 32'h020a_8000},
    {4'hd, 32'h0d62_0a90}};

  vcmbd_decoder vcmbd_decoder_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mb_params(mb_params), .fetch_mask(fetch_mask),
    .mb_valid(mb_valid), .mb_error(mb_error));

  vcmbd_streamer vcmbd_streamer_inst (
    .pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hung(hung));

  task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
    begin
      num_checks++;
      if (got !== exp)
      begin
        $display("[FAIL] %s expected %h seen %h", what, exp, got);
        err_count++;
      end
    end
  endtask

  task automatic end_sim();
    begin
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  always @(posedge hung)
  begin
    err_count++;
    end_sim();
  end

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      @(posedge pclk);
      vcmbd_streamer_inst.xfer(w, a, d, rd, er);
    end
  endtask

  task automatic run_cmd(input logic [3:0] ctrl, input logic [31:0] dw0,
                         input logic [15:0] dw1, input logic ok);
    logic v;
    logic e;
    int   n;
    begin
      bus(1'b1, A_CTRL, {28'h0, ctrl});
      bus(1'b1, 12'h050, dw0);
      bus(1'b1, 12'h054, {16'h0, dw1});
      for (int i = 0; i < 5; i++)
        bus(1'b1, 12'h058 + 12'(4 * i), 32'h0004_fffc);
      bus(1'b1, 12'h06c, 32'h3f2a_0500);
      bus(1'b1, 12'h070, 32'h0000_1e07);
      v = 1'b0;
      e = 1'b0;
      n = 0;
      while (!v && !e && n < 10)
      begin
        @(posedge pclk);
        v = (mb_valid === 1'b1);
        e = (mb_error === 1'b1);
        n++;
      end
      if (!v && !e)
      begin
        err_count++;
        end_sim();
      end
      if (ok)
      begin
        last_p = {dw0[26:24], dw0[22:4], dw1};
        last_f = dw0[16] ? 6'h3f : dw0[11:6];
        // intra drops every prediction field
        if (dw0[16])
        begin
          last_p.chroma_ref_field_polarity = 1'b0;
          last_p.field_direction_swap      = 1'b0;
          last_p.backward_vector_active    = 1'b0;
          last_p.forward_vector_active     = 1'b0;
        end
      end
      check("valid pulse", v, ok);
      check("error pulse", e, !ok);
      check("params", mb_params, last_p);
      check("fetch", fetch_mask, last_f);
    end
  endtask

  task automatic t_regs();
    begin
      check("params at reset", mb_params, 0);
      bus(1'b0, A_CTRL, 32'h0);
      check("ctrl reset", rd, 32'h8);
      bus(1'b0, 12'h0fc, 32'h0);
      check("unmapped err", er, 1'b1);
      check("unmapped data", rd, 32'h0);
      bus(1'b1, 12'h0fc, 32'h5);
      check("unmapped write err", er, 1'b1);
      $display("test regs done");
    end
  endtask

  task automatic t_good();
    begin
      for (int i = 0; i < 5; i++)
        run_cmd(good_tab[i][51:48], good_tab[i][47:16], good_tab[i][15:0], 1'b1);
      $display("test good done");
    end
  endtask

  task automatic t_sub();
    begin
      bus(1'b0, A_SBC, 32'h0);
      check("luma subblocks", rd, 32'h3f22_1100);
      bus(1'b0, A_SBC_C, 32'h0);
      check("chroma subblocks", rd, 32'h0000_2331);
      bus(1'b0, A_P0, 32'h0);
      check("decoded dword0", rd, good_tab[4][47:16]);
      bus(1'b0, A_CVEC, 32'h0);
      check("chroma vector", rd, 32'h0004_fffc);
      bus(1'b0, 12'h050, 32'h0);
      check("dword0 readback", rd, good_tab[4][47:16]);
      bus(1'b0, 12'h070, 32'h0);
      check("last dword readback", rd, 32'h0000_1e07);
      $display("test subblock done");
    end
  endtask

  task automatic t_bad();
    begin
      // every entry breaks at least one combination and must leave outputs alone
      for (int i = 0; i < 13; i++)
        run_cmd(bad_tab[i][35:32], bad_tab[i][31:0], 16'h4321, 1'b0);
      bus(1'b0, A_STATUS, 32'h0);
      check("sticky error", rd[0], 1'b1);
      bus(1'b0, A_ERRCNT, 32'h0);
      check("error count", rd[7:0], 8'h0d);
      bus(1'b1, A_STATUS, 32'h1);
      bus(1'b0, A_STATUS, 32'h0);
      check("sticky cleared", rd[0], 1'b0);
      run_cmd(good_tab[0][51:48], good_tab[0][47:16], good_tab[0][15:0], 1'b1);
      $display("test malformed done");
    end
  endtask

  // a launch pending while the clock enable is low must wait for it
  task automatic t_freeze();
    begin
      bus(1'b0, A_CVEC, 32'h0);
      check("chroma vector hidden", rd, 32'h0);
      bus(1'b1, 12'h070, 32'h0000_1e07);
      clk_en <= 1'b0;
      for (int i = 0; i < 3; i++)
      begin
        @(posedge pclk);
        check("frozen valid", mb_valid, 1'b0);
      end
      clk_en <= 1'b1;
      repeat (2) @(posedge pclk);
      check("thawed valid", mb_valid, 1'b1);
      check("thawed params", mb_params, last_p);
      $display("test freeze done");
    end
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial
  begin
    presetn = 1'b0;
    clk_en = 1'b1;
    err_count = 0;
    num_checks = 0;
    last_p = '0;
    last_f = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_good();
    t_sub();
    t_bad();
    t_freeze();
    end_sim();
  end
endmodule

// ==== bench/vcmbd_streamer.sv ====
`timescale 1ns/1ps
module vcmbd_streamer (
  input  wire logic        pclk,    // pipeline clock
  input  wire logic        pready,  // slave ready
  input  wire logic [31:0] prdata,  // slave read data
  input  wire logic        pslverr, // slave error
  output logic             psel,    // select
  output logic             penable, // access phase
  output logic             pwrite,  // direction
  output logic      [11:0] paddr,   // byte address
  output logic      [31:0] pwdata,  // write data
  output logic             hung     // answer never came
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    hung    = 1'b0;
  end

  // caller enters just after an edge; request held until pready is sampled
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    begin
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge pclk);
        n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
        hung <= 1'b1;
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
endmodule

// ==== rtl/vcmbd_decoder.sv ====
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Contract
// R1 - bit 26 chroma reference field, non-intra only
// R2 - bits 25:24 decode intra, field, frame
// R3 - frame picture: motion kind 00 or 10
// R4 - field motion iff field residual, non-intra
// R5 - motion kind 00 exactly when intra
// R6 - bit 22 swaps direction between fields
// R7 - bit 21 field residual, intra/field only
// R8 - progressive picture keeps residual bit zero
// R9 - bit 20 requests overlap smoothing
// R10 - four-vector only progressive P, forward active
// R11 - backward vector zero in four-vector mode
// R12 - bit 17 forward vector active
// R13 - intra ignores pattern, no prediction
// R14 - bits 15:12 luma intra, four-vector only
// R15 - bits 11:6 residue block presence
// R16 - intra blocks must have pattern bit
// R17 - bit 5 chroma treated as intra
// R18 - bit 4 marks last macroblock row
// R19 - second dword holds row and column
// R20 - chroma vector invalid for interlaced field motion
// R21 - subblock byte split and presence bits
// R22 - malformed command never corrupts residual fetch
module vcmbd_decoder
  import vcmbd_pkg::*;
(
  input  wire logic                 pclk,        // pipeline clock
  input  wire logic                 presetn,     // async reset, low
  input  wire logic                 clk_en,      // freezes all state when low
  input  wire logic                 psel,        // apb select
  input  wire logic                 penable,     // apb access phase
  input  wire logic                 pwrite,      // apb direction
  input  wire logic [11:0]          paddr,       // apb byte address
  input  wire logic [31:0]          pwdata,      // apb write data
  output logic      [31:0]          prdata,      // apb read data
  output logic                      pready,      // apb ready
  output logic                      pslverr,     // apb error
  output vcmbd_pkg::vcmbd_params_t  mb_params,   // decoded fields
  output logic      [5:0]           fetch_mask,  // residue blocks to fetch
  output logic                      mb_valid,    // one-cycle decode pulse
  output logic                      mb_error     // one-cycle malformed pulse
);
  import vcmbd_pkg::*;

  logic [31:0]    dw_reg [DW_INLINE0:DW_LAST];
  logic [3:0]     ctrl_reg;
  logic [7:0]     err_cnt_reg;
  logic           sticky_err_reg;
  logic           go_next;
  vcmbd_params_t  p_next;
  logic [5:0]     fetch_next;
  logic           bad_next;
  logic           cvec_ok_reg;
  logic           cvec_ok_next;

  function automatic logic [11:0] dw_addr(input int idx);
    dw_addr = A_DW_BASE + 12'(idx * 4);
  endfunction

  function automatic vcmbd_sbc_t sbc_decode(input logic [7:0] b);
    vcmbd_sbc_t s;
    s.split = vcmbd_split_t'(b[1:0]);
    // unused presence bits are don't care per split
    case (s.split)
      SP_ONE_8X8:  s.sub_present = {3'h0, b[2]};
      SP_TWO_8X4,
      SP_TWO_4X8:  s.sub_present = {2'h0, b[3:2]};
      default:     s.sub_present = b[5:2];
    endcase
    return s;
  endfunction

  wire logic apb_acc = psel && penable && clk_en;
  wire logic apb_wr  = apb_acc && pwrite;

  // the last dword write launches the decode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      go_next <= 1'b0;
    else if (clk_en)
      go_next <= apb_wr && paddr == dw_addr(DW_LAST);
  end

  for (genvar i = DW_INLINE0; i <= DW_LAST; i++) begin : g_dw
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        dw_reg[i] <= 32'h0000_0000;
      else if (apb_wr && paddr == dw_addr(i))
        dw_reg[i] <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= CTRL_RESET;
    else if (apb_wr && paddr == A_CTRL)
      ctrl_reg <= pwdata[3:0];
  end

  // field decode and consistency checks
  always_comb
  begin
    logic [31:0] d0;
    logic        il;
    logic        intra;
    logic        fv;
    d0 = dw_reg[DW_INLINE0];
    il = ctrl_reg[CTRL_INTERLACED];
    intra = d0[POS_INTRA];
    fv = d0[POS_FOUR_VEC];
    p_next.chroma_ref_field_polarity  = d0[POS_CHROMA_POL];                   // R1
    p_next.motion_kind = vcmbd_motion_t'(d0[POS_MOTION_HI:POS_MOTION_LO]);     // R2
    p_next.field_direction_swap       = d0[POS_DIR_SWAP];                     // R6
    p_next.residual_structure         = d0[POS_RESID_STRUCT];                 // R7
    p_next.overlap_smoothing_on       = d0[POS_OVERLAP];                      // R9
    p_next.four_vector_mode           = d0[POS_FOUR_VEC];
    p_next.backward_vector_active     = d0[POS_BACKWARD];
    p_next.forward_vector_active      = d0[POS_FORWARD];                      // R12
    p_next.intra_macroblock_flag      = d0[POS_INTRA];
    p_next.luma_block_intra_bits      = d0[POS_LUMA_INTRA_HI:POS_LUMA_INTRA_LO]; // R14
    p_next.residue_block_present_bits = d0[POS_CBP_HI:POS_CBP_LO];             // R15
    p_next.chroma_as_intra            = d0[POS_CHROMA_INTRA];                 // R17
    p_next.final_row_marker           = d0[POS_FINAL_ROW];                    // R18
    p_next.mb_row_position    = dw_reg[DW_ORIGIN][POS_ROW_HI:POS_ROW_LO];     // R19
    p_next.mb_column_position = dw_reg[DW_ORIGIN][POS_COL_HI:POS_COL_LO];     // R19
    if (intra)
    begin
      // intra: no prediction, chroma polarity meaningless
      p_next.chroma_ref_field_polarity = 1'b0;                                // R1
      p_next.forward_vector_active     = 1'b0;                                // R13
      p_next.backward_vector_active    = 1'b0;                                // R13
      p_next.field_direction_swap      = 1'b0;                                // R13
    end
    bad_next = p_next.motion_kind == MK_RESERVED;                             // R22
    bad_next |= (p_next.motion_kind == MK_INTRA) != intra;                    // R5
    bad_next |= !il && p_next.motion_kind == MK_FIELD;                        // R3
    bad_next |= p_next.residual_structure
                && !(p_next.motion_kind inside {MK_INTRA, MK_FIELD});         // R7
    bad_next |= !intra && (p_next.motion_kind == MK_FIELD)
                != p_next.residual_structure;                                 // R4
    bad_next |= !il && p_next.residual_structure;                             // R8
    bad_next |= fv && (il || !ctrl_reg[CTRL_PICTURE_P]
                || !p_next.forward_vector_active);                            // R10
    bad_next |= fv && p_next.backward_vector_active;                          // R11
    bad_next |= !fv && |p_next.luma_block_intra_bits;                         // R14
    bad_next |= intra && !(&p_next.residue_block_present_bits);               // R16
    bad_next |= fv && |(p_next.luma_block_intra_bits
                & ~p_next.residue_block_present_bits[5:2]);                   // R16
    bad_next |= ctrl_reg[CTRL_STRICT_RSVD] && (|(d0 & DW0_RSVD_MASK)
                || |(dw_reg[DW_ORIGIN] & DW1_RSVD_MASK)
                || |(dw_reg[DW_SBC_C] & DW8_RSVD_MASK));
    cvec_ok_next = !(il && p_next.motion_kind == MK_FIELD);                   // R20
    // pattern is only honoured for accepted non-intra blocks
    if (bad_next)
      fetch_next = 6'h00;                                                     // R22
    else if (intra)
      fetch_next = 6'h3f;                                                     // R13
    else
      fetch_next = p_next.residue_block_present_bits;                         // R15
  end

  // decoded outputs only change on an accepted command, so errors leave them alone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mb_params   <= '0;
      fetch_mask  <= 6'h00;
      cvec_ok_reg <= 1'b0;
    end
    else if (clk_en && go_next && !bad_next)
    begin
      mb_params   <= p_next;
      fetch_mask  <= fetch_next;                                              // R22
      cvec_ok_reg <= cvec_ok_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mb_valid <= 1'b0;
      mb_error <= 1'b0;
    end
    else if (clk_en)
    begin
      mb_valid <= go_next && !bad_next;
      mb_error <= go_next && bad_next;                                        // R22
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sticky_err_reg <= 1'b0;
      err_cnt_reg    <= 8'h00;
    end
    else if (clk_en)
    begin
      if (go_next && bad_next)
      begin
        sticky_err_reg <= 1'b1;
        if (err_cnt_reg != 8'hff)
          err_cnt_reg <= err_cnt_reg + 8'h01;
      end
      else if (apb_wr && paddr == A_STATUS && pwdata[0])
        sticky_err_reg <= 1'b0;
    end
  end

  // read mux; subblock bytes are split-masked before they are shown
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable)
      begin
        if (paddr == A_CTRL)
          prdata <= {28'h0, ctrl_reg};
        else if (paddr == A_STATUS)
          prdata <= {30'h0, cvec_ok_reg, sticky_err_reg};
        else if (paddr == A_P0)
          prdata <= {5'h0, mb_params.chroma_ref_field_polarity,
                     mb_params.motion_kind, 1'b0, mb_params.field_direction_swap,
                     mb_params.residual_structure, mb_params.overlap_smoothing_on,
                     mb_params.four_vector_mode, mb_params.backward_vector_active,
                     mb_params.forward_vector_active, mb_params.intra_macroblock_flag,
                     mb_params.luma_block_intra_bits,
                     mb_params.residue_block_present_bits,
                     mb_params.chroma_as_intra, mb_params.final_row_marker, 4'h0};
        else if (paddr == A_P1)
          prdata <= {16'h0, mb_params.mb_row_position, mb_params.mb_column_position};
        else if (paddr == A_CVEC)
          prdata <= cvec_ok_reg ? dw_reg[DW_MV_CHROMA] : 32'h0000_0000;       // R20
        else if (paddr == A_SBC)
          prdata <= {2'h0, sbc_decode(dw_reg[DW_SBC_Y][31:24]),
                     2'h0, sbc_decode(dw_reg[DW_SBC_Y][23:16]),
                     2'h0, sbc_decode(dw_reg[DW_SBC_Y][15:8]),
                     2'h0, sbc_decode(dw_reg[DW_SBC_Y][7:0])};                // R21
        else if (paddr == A_SBC_C)
          prdata <= {16'h0, 2'h0, sbc_decode(dw_reg[DW_SBC_C][15:8]),
                     2'h0, sbc_decode(dw_reg[DW_SBC_C][7:0])};                // R21
        else if (paddr == A_FETCH)
          prdata <= {26'h0, fetch_mask};
        else if (paddr == A_ERRCNT)
          prdata <= {24'h0, err_cnt_reg};
        else if (paddr >= dw_addr(DW_INLINE0) && paddr <= dw_addr(DW_LAST)
                 && paddr[1:0] == 2'h0)
          prdata <= dw_reg[paddr[5:2]];
        else
          pslverr <= 1'b1;
      end
    end
  end

  intra_fetch_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
    mb_valid |-> (mb_params.intra_macroblock_flag == (fetch_mask == 6'h3f)
                  || !mb_params.intra_macroblock_flag))
    else $error("intra macroblock did not fetch every block");
  bad_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R22
    mb_error |-> $stable(fetch_mask) && $stable(mb_params))
    else $error("malformed command changed decoded state");
  kind_match_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
    mb_valid |-> (mb_params.motion_kind == MK_INTRA) == mb_params.intra_macroblock_flag)
    else $error("accepted command with intra mismatch");
  no_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
    mb_valid |-> mb_params.motion_kind != MK_RESERVED)
    else $error("reserved motion kind accepted");
  resid_kind_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
    mb_valid && mb_params.residual_structure |-> mb_params.motion_kind != MK_FRAME)
    else $error("field residual with frame motion");
  four_back_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
    mb_valid && mb_params.four_vector_mode |-> !mb_params.backward_vector_active
                                               && mb_params.forward_vector_active)
    else $error("four-vector with bad direction flags");
  intra_pred_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
    mb_valid && mb_params.intra_macroblock_flag |-> !mb_params.forward_vector_active
                                                    && !mb_params.chroma_ref_field_polarity)
    else $error("intra macroblock kept prediction");
  valid_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // R22
    mb_valid |-> !mb_error && $past(go_next))
    else $error("decode pulse without launch");
  fetch_cbp_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
    mb_valid && !mb_params.intra_macroblock_flag
      |-> fetch_mask == mb_params.residue_block_present_bits)
    else $error("fetch mask differs from block pattern");
  luma_mode_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
    mb_valid && !mb_params.four_vector_mode |-> mb_params.luma_block_intra_bits == 4'h0)
    else $error("luma intra bits outside four-vector mode");
endmodule

// ==== rtl/vcmbd_pkg.sv ====
package vcmbd_pkg;
  // command dword indices within the macroblock command
  localparam int DW_INLINE0  = 4;
  localparam int DW_ORIGIN   = 5;
  localparam int DW_MV0      = 6;
  localparam int DW_MV_CHROMA = 10;
  localparam int DW_SBC_Y    = 11;
  localparam int DW_SBC_C    = 12;
  localparam int DW_LAST     = 12;
  localparam logic [3:0] DW_IDX_W1 = 4'hc;

  // dword 0 field positions, then dword 1 row/column positions and subblock sizes
  localparam int POS_CHROMA_POL   = 26;
  localparam int POS_MOTION_HI    = 25;
  localparam int POS_MOTION_LO    = 24;
  localparam int POS_DIR_SWAP     = 22;
  localparam int POS_RESID_STRUCT = 21;
  localparam int POS_OVERLAP      = 20;
  localparam int POS_FOUR_VEC     = 19;
  localparam int POS_BACKWARD     = 18;
  localparam int POS_FORWARD      = 17;
  localparam int POS_INTRA        = 16;
  localparam int POS_LUMA_INTRA_HI = 15;
  localparam int POS_LUMA_INTRA_LO = 12;
  localparam int POS_CBP_HI       = 11;
  localparam int POS_CBP_LO       = 6;
  localparam int POS_CHROMA_INTRA = 5;
  localparam int POS_FINAL_ROW    = 4;
  localparam int POS_ROW_HI = 15;
  localparam int POS_ROW_LO = 8;
  localparam int POS_COL_HI = 7;
  localparam int POS_COL_LO = 0;
  localparam int SBC_W = 8;
  localparam int NUM_SBC = 6;

  // dword 0 reserved-zero bits: 27, 23, 3:0
  localparam logic [31:0] DW0_RSVD_MASK = 32'h0880_000f;
  localparam logic [31:0] DW1_RSVD_MASK = 32'hffff_0000;
  localparam logic [31:0] DW8_RSVD_MASK = 32'hffff_0000;

  typedef enum logic [1:0] {
    MK_INTRA    = 2'h0,
    MK_FIELD    = 2'h1,
    MK_FRAME    = 2'h2,
    MK_RESERVED = 2'h3
  } vcmbd_motion_t;

  typedef enum logic [1:0] {
    SP_ONE_8X8  = 2'h0,
    SP_TWO_8X4  = 2'h1,
    SP_TWO_4X8  = 2'h2,
    SP_FOUR_4X4 = 2'h3
  } vcmbd_split_t;

  typedef struct packed {
    vcmbd_split_t split;
    logic [3:0]   sub_present;
  } vcmbd_sbc_t;

  typedef struct packed {
    logic          chroma_ref_field_polarity;
    vcmbd_motion_t motion_kind;
    logic          field_direction_swap;
    logic          residual_structure;
    logic          overlap_smoothing_on;
    logic          four_vector_mode;
    logic          backward_vector_active;
    logic          forward_vector_active;
    logic          intra_macroblock_flag;
    logic [3:0]    luma_block_intra_bits;
    logic [5:0]    residue_block_present_bits;
    logic          chroma_as_intra;
    logic          final_row_marker;
    logic [7:0]    mb_row_position;
    logic [7:0]    mb_column_position;
  } vcmbd_params_t;

  // register bank offsets (byte addresses)
  localparam logic [11:0] A_CTRL    = 12'h000;
  localparam logic [11:0] A_STATUS  = 12'h004;
  localparam logic [11:0] A_DW_BASE = 12'h040;
  localparam logic [11:0] A_P0      = 12'h080;
  localparam logic [11:0] A_P1      = 12'h084;
  localparam logic [11:0] A_CVEC    = 12'h088;
  localparam logic [11:0] A_SBC     = 12'h08c;
  localparam logic [11:0] A_SBC_C   = 12'h090;
  localparam logic [11:0] A_FETCH   = 12'h094;
  localparam logic [11:0] A_ERRCNT  = 12'h098;
  localparam int CTRL_INTERLACED  = 0;
  localparam int CTRL_PICTURE_P   = 1;
  localparam int CTRL_PICTURE_B   = 2;
  localparam int CTRL_STRICT_RSVD = 3;
  localparam logic [3:0] CTRL_RESET = 4'h8;
endpackage
